// ==== tb_vtx_out_port.sv ====
// Self-checking bench for the packet output port
`timescale 1ns/100ps
module tb_vtx_out_port;
    import vtx_pkg::*;
    logic        mclk_in = 1'b0, sys_rst_in = 1'b1, mode = 1'b0;
    logic        src_valid_in = 1'b0, src_last_in = 1'b0, src_ready_out;
    logic [63:0] src_data_in = 64'h0, pout_tdata_out;
    vtx_desc_t   src_desc_in = '0;
    vtx_user_t   pout_tuser_out;
    logic        pout_tvalid_out, pout_tready_in, pout_tlast_out;
    logic        s_axi_aclk_in, s_axi_aresetn_in = 1'b0;
    logic [31:0] s_axi_awaddr_in = 32'h0, s_axi_wdata_in = 32'h0;
    logic [31:0] s_axi_araddr_in = 32'h0, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = 4'h0;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic        s_axi_rready_in = 1'b0, s_axi_awready_out, s_axi_wready_out;
    logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [96:0] exp_q[$];
    logic [96:0] e, m;
    int          n_mismatch = 0, cmp_count = 0;
    wire  [96:0] got = {pout_tlast_out, pout_tuser_out, pout_tdata_out};
    // Host port shares the core clock; the block has one clock here
    assign s_axi_aclk_in = mclk_in;
    always #4 mclk_in = ~mclk_in;
    vtx_out_port DUT (.*);
    vtx_sink u_sink (.mclk_in, .sys_rst_in, .ready_out(pout_tready_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [96:0] g, x);
        cmp_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait, a hang counts as a mismatch
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 60 && s !== 1'b1; i++) @(posedge mclk_in) #1;
        if (s !== 1'b1) begin
            n_mismatch++;
            end_of_test;
        end
    endtask
    task automatic host_wr(input logic [31:0] a, d, input logic [3:0] st,
                           input logic [1:0] er);
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_wstrb_in} = {a, d, st};
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h7;
        wait_hi(s_axi_bvalid_out);
        chk(97'(s_axi_bresp_out), 97'(er));
        @(posedge mclk_in) #1;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    endtask
    task automatic host_rd(input logic [31:0] a, x, input logic [1:0] er);
        s_axi_araddr_in = a;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h3;
        wait_hi(s_axi_rvalid_out);
        chk(97'({s_axi_rresp_out, s_axi_rdata_out}), 97'({er, x}));
        @(posedge mclk_in) #1;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    endtask
    // Words go back to back; expectation queued before each of the first 256 takes
    task automatic send_pkt(input vtx_src_t s, input logic [3:0] mt,
                            input int nw);
        vtx_user_t u;
        src_desc_in = '{s, mt, 12'(nw) + 12'h0A0, 11'(nw * 8)};
        u = '{s == VTX_SRC_MEDIA ? mt : {1'b0, mode, 1'b1, s == VTX_SRC_ROW},
              1'b0, src_desc_in.len, 1'b0, src_desc_in.chan, 2'h0, 1'b1};
        for (int k = 0; k < nw; k++) begin
            {src_valid_in, src_last_in} = {1'b1, k == nw - 1};
            for (int j = 0; j < 8; j++) src_data_in[j*8+:8] = 8'(k * 8 + j);
            wait_hi(src_ready_out);
            if (k < 256)
                exp_q.push_back({k == nw - 1 || k == 255, u, src_data_in});
            u.sop = 1'b0;
            @(posedge mclk_in) #1;
        end
        // One idle edge so the next packet never re-raises valid at once
        src_valid_in = 1'b0;
        @(posedge mclk_in) #1;
    endtask
    task automatic drain;
        for (int i = 0; i < 99 && exp_q.size() > 0; i++) @(posedge mclk_in) #1;
        chk(97'(exp_q.size()), 97'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Media packets of every type, one to four words long
    task automatic sc_media;
        logic [3:0] ty[4] = '{4'h0, 4'h5, 4'h8, 4'h9};
        foreach (ty[i]) send_pkt(VTX_SRC_MEDIA, ty[i], i + 1);
    endtask
    // FEC packet types follow the rate mode
    task automatic sc_fec;
        send_pkt(VTX_SRC_COL, 4'h0, 2);
        send_pkt(VTX_SRC_ROW, 4'h0, 3);
    endtask
    // Strobed write, unmapped accesses, then the rate mode switched on
    task automatic sc_host;
        host_wr(32'h0, 32'hFFFF_FFFF, 4'h2, 2'h0);
        host_rd(32'h0, 32'h0000_FF00, 2'h0);
        host_wr(32'h4, 32'h0000_0001, 4'hF, 2'h2);
        host_rd(32'h4, 32'h0, 2'h2);
        host_wr(32'h0, 32'h0000_0001, 4'h1, 2'h0);
        host_rd(32'h0, 32'h0000_FF01, 2'h0);
        mode = 1'b1;
    endtask
    // Each accepted word against the next expected one
    always @(posedge mclk_in)
        if (!sys_rst_in && pout_tvalid_out === 1'b1 && pout_tready_in) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            m = {1'b1, e[64] ? 32'hFFFF_FFFF : 32'h0800_8007, 64'h0 - 64'h1};
            chk(got & m, e & m);
        end
    initial begin
        repeat (10) @(posedge mclk_in);
        #1;
        {sys_rst_in, s_axi_aresetn_in} = 2'h1;
        chk(97'({pout_tvalid_out, s_axi_bvalid_out}), 97'h0);
        sc_media;
        sc_fec;
        sc_host;
        sc_fec;
        send_pkt(VTX_SRC_MEDIA, 4'h0, 258);
        drain;
        end_of_test;
    end
endmodule

// ==== vtx_defs.svh ====
// Constants for the packet output port: sideband, codes, limits, host map
// Operation
// R01: Valid held from first to last packet word
// R02: Last flag only on final packet word
// R03: Sideband bit 0 marks first packet word
// R04: Protocol version bits 2:1 always 00
// R05: Channel 14:3 and byte length 26:16 at start
// R06: Packet type 31:28; 2022-1 column 0010, row 0011
// R07: 2022-5 mode: column 0110, row 0111
// R08: Media types 0000, 0101, 1000, 1001 passed through
// R09: First byte in lane 7:0, ascending after
// R10: Outgoing packets never exceed 2 kilobytes
// R11: Host port is 32-bit AXI4-Lite
// R12: Write strobes update only selected bytes
// R13: Host port own clock, active-low reset
// R14: Two-bit response on every write and read
// R15: Stream logic on the single core clock
// R16: Core reset active high, synchronous
// R17: Transfer on valid and ready; hold when stalled
// R18: Reserved sideband bits 15 and 27 zero
// R19: Output data word is 64 bits
`ifndef VTX_DEFS_SVH
`define VTX_DEFS_SVH
`define VTX_DATA_W       64
`define VTX_MAX_BYTES    2048
`define VTX_PROTO_VER    2'h0
`define VTX_TYPE_UDP     4'h0
`define VTX_TYPE_COL_1   4'h2
`define VTX_TYPE_ROW_1   4'h3
`define VTX_TYPE_2022_6  4'h5
`define VTX_TYPE_COL_5   4'h6
`define VTX_TYPE_ROW_5   4'h7
`define VTX_TYPE_RFC4175 4'h8
`define VTX_TYPE_RFC3190 4'h9
`define VTX_REG_CTRL     32'h0000_0000
`define VTX_CTRL_RST     32'h0000_0000
`define VTX_CTRL_MODE_B  0
`define VTX_RESP_OKAY    2'h0
`define VTX_RESP_SLVERR  2'h2
`endif

// ==== vtx_out_port.sv ====
// Packet output stream with sideband tagging and AXI4-Lite control port
`timescale 1ns/100ps
`include "vtx_defs.svh"
module vtx_out_port
    import vtx_pkg::*;
#(
    parameter int DATA_W    = `VTX_DATA_W,
    parameter int MAX_BYTES = `VTX_MAX_BYTES
) (
    // Core clock and reset
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    // Packet source, same clock
    input  wire logic              src_valid_in,
    output logic                   src_ready_out,
    input  wire logic [DATA_W-1:0] src_data_in,
    input  wire logic              src_last_in,
    input  wire vtx_desc_t         src_desc_in,
    // Outgoing packet stream
    output logic                   pout_tvalid_out,
    input  wire logic              pout_tready_in,
    output logic [DATA_W-1:0]      pout_tdata_out,
    output logic                   pout_tlast_out,
    output vtx_user_t              pout_tuser_out,
    // Host register port
    input  wire logic              s_axi_aclk_in,
    input  wire logic              s_axi_aresetn_in,
    input  wire logic [31:0]       s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [31:0]       s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in
);
    localparam int MAX_WORDS = MAX_BYTES / (DATA_W / 8);
    localparam int CNT_W     = $clog2(MAX_WORDS);

    ////////////////////////////////////////////////////////////////////////
    // Host register port, own clock and active-low reset
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl;
    wire         wr_go  = s_axi_awvalid_in && s_axi_wvalid_in &&
                          !s_axi_bvalid_out && !s_axi_awready_out;
    wire         wr_hit = (s_axi_awaddr_in == `VTX_REG_CTRL);
    wire         rd_go  = s_axi_arvalid_in && !s_axi_rvalid_out &&
                          !s_axi_arready_out;
    wire         rd_hit = (s_axi_araddr_in == `VTX_REG_CTRL);
    logic [31:0] next_ctrl;

    // Byte lanes merge only where the strobe is set
    always_comb begin
        next_ctrl = ctrl;
        for (int b = 0; b < 4; b++) begin
            if (s_axi_wstrb_in[b]) begin // [R12]
                next_ctrl[8*b +: 8] = s_axi_wdata_in[8*b +: 8];
            end
        end
    end

    // Write channel: address and data taken together in one pulse
    always_ff @(posedge s_axi_aclk_in) begin // [R13]
        if (!s_axi_aresetn_in) begin
            ctrl              <= `VTX_CTRL_RST;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `VTX_RESP_OKAY;
        end else begin
            s_axi_awready_out <= wr_go; // [R11]
            s_axi_wready_out  <= wr_go;
            if (wr_go && wr_hit) begin
                ctrl <= next_ctrl;
            end
            if (wr_go) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_hit ? `VTX_RESP_OKAY
                                           : `VTX_RESP_SLVERR; // [R14]
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Read channel: unmapped addresses read zero with an error code
    always_ff @(posedge s_axi_aclk_in) begin
        if (!s_axi_aresetn_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `VTX_RESP_OKAY;
        end else begin
            s_axi_arready_out <= rd_go; // [R11]
            if (rd_go) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= rd_hit ? ctrl : 32'h0000_0000;
                s_axi_rresp_out  <= rd_hit ? `VTX_RESP_OKAY
                                           : `VTX_RESP_SLVERR; // [R14]
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode bit into the core domain through two flip-flops
    ////////////////////////////////////////////////////////////////////////
    logic mode_meta;
    logic mode_5;

    // Quasi-static level; a change mid-packet alters ptype on the remaining words of that FEC packet
    always_ff @(posedge mclk_in) begin // [R15]
        if (sys_rst_in) begin
            mode_meta <= 1'b0;
            mode_5    <= 1'b0;
        end else begin
            mode_meta <= ctrl[`VTX_CTRL_MODE_B];
            mode_5    <= mode_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Packet type and sideband construction
    ////////////////////////////////////////////////////////////////////////
    logic      in_pkt;
    logic      drop;
    logic [CNT_W-1:0] wcnt;
    logic [3:0] ptype;
    vtx_user_t next_user;

    // FEC codes depend on the rate mode; media codes pass straight on
    always_comb begin
        case (src_desc_in.src)
            VTX_SRC_COL: begin
                ptype = mode_5 ? `VTX_TYPE_COL_5 : `VTX_TYPE_COL_1; // [R06] [R07]
            end
            VTX_SRC_ROW: begin
                ptype = mode_5 ? `VTX_TYPE_ROW_5 : `VTX_TYPE_ROW_1; // [R06] [R07]
            end
            default: begin
                ptype = src_desc_in.media_type; // [R08]
            end
        endcase
    end

    // Descriptor fields are given on every word, sop only on the first
    always_comb begin
        next_user       = '0;
        next_user.sop   = !in_pkt; // [R03]
        next_user.ver   = `VTX_PROTO_VER; // [R04]
        next_user.chan  = src_desc_in.chan; // [R05]
        next_user.len   = src_desc_in.len; // [R05]
        next_user.rsv15 = 1'b0; // [R18]
        next_user.rsv27 = 1'b0; // [R18]
        next_user.ptype = ptype; // [R06]
    end

    ////////////////////////////////////////////////////////////////////////
    // Output register stage with size limit
    ////////////////////////////////////////////////////////////////////////
    wire out_free = !pout_tvalid_out || pout_tready_in;
    wire take     = src_valid_in && src_ready_out;
    wire at_limit = (wcnt == CNT_W'(MAX_WORDS - 1));
    wire cut_last = src_last_in || at_limit;

    // Ready is a plain term so the source stalls with the output
    assign src_ready_out = out_free || drop; // [R17]

    // Words beyond the limit are discarded up to the source's own last
    always_ff @(posedge mclk_in) begin // [R16]
        if (sys_rst_in) begin
            pout_tvalid_out <= 1'b0;
            pout_tdata_out  <= '0;
            pout_tlast_out  <= 1'b0;
            pout_tuser_out  <= '0;
            in_pkt          <= 1'b0;
            drop            <= 1'b0;
            wcnt            <= '0;
        end else if (drop) begin
            if (src_valid_in && src_last_in) begin
                drop <= 1'b0;
            end
            if (pout_tready_in) begin
                pout_tvalid_out <= 1'b0;
            end
        end else if (out_free) begin
            pout_tvalid_out <= src_valid_in; // [R01] [R17]
            if (take) begin
                pout_tdata_out <= src_data_in; // [R09] [R19]
                pout_tlast_out <= cut_last; // [R02] [R10]
                pout_tuser_out <= next_user;
                in_pkt         <= !cut_last;
                wcnt           <= cut_last ? '0 : wcnt + 1'b1;
                drop           <= at_limit && !src_last_in; // [R10]
            end
        end
    end
endmodule

// ==== vtx_out_port_props.sv ====
// Concurrent checks on the packet output port
`timescale 1ns/100ps
module vtx_out_port_props
    import vtx_pkg::*;
(
    // Stream side
    input wire logic       mclk_in,
    input wire logic       sys_rst_in,
    input wire logic       pout_tvalid_out,
    input wire logic       pout_tready_in,
    input wire logic       pout_tlast_out,
    input wire vtx_user_t  pout_tuser_out,
    // Host side
    input wire logic       s_axi_aclk_in,
    input wire logic       s_axi_aresetn_in,
    input wire logic       s_axi_awvalid_in,
    input wire logic       s_axi_wvalid_in,
    input wire logic       s_axi_awready_out,
    input wire logic       s_axi_wready_out,
    input wire logic       s_axi_bvalid_out,
    input wire logic       s_axi_bready_in,
    input wire logic       s_axi_arvalid_in,
    input wire logic       s_axi_arready_out,
    input wire logic       s_axi_rvalid_out
);
    // Two clock domains here, so every property names its own clock
    wire hs = pout_tvalid_out && pout_tready_in;
    ////////////////////////////////////////////////////////////////////////
    // Stream framing; a stalled word must keep valid, sideband and last
    a_stall_hold: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in) pout_tvalid_out && !pout_tready_in |=>
        pout_tvalid_out && $stable(pout_tuser_out) && $stable(pout_tlast_out))
        else $error("Word changed in stall");
    a_ver_zero: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        pout_tvalid_out |-> pout_tuser_out.ver == 2'h0) else $error("Ver");
    a_rsv_zero: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        pout_tvalid_out |-> !pout_tuser_out.rsv15 && !pout_tuser_out.rsv27)
        else $error("Reserved bit set");
    a_sop_after_last: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        hs && pout_tlast_out |=> !pout_tvalid_out || pout_tuser_out.sop)
        else $error("No start after last");
    a_sop_inner: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        hs && !pout_tlast_out |=> !(pout_tvalid_out && pout_tuser_out.sop))
        else $error("Start inside packet");
    ////////////////////////////////////////////////////////////////////////
    // Host port answers in the cycle the request is taken, one cycle after it is seen
    a_wr_answer: assert property (@(posedge s_axi_aclk_in)
        disable iff (!s_axi_aresetn_in) s_axi_awvalid_in && s_axi_wvalid_in
        && !s_axi_bvalid_out && !s_axi_awready_out |=> s_axi_awready_out
        && s_axi_wready_out && s_axi_bvalid_out) else $error("Write");
    a_bresp_once: assert property (@(posedge s_axi_aclk_in)
        disable iff (!s_axi_aresetn_in) s_axi_bvalid_out && s_axi_bready_in
        |=> !s_axi_bvalid_out) else $error("Response repeated");
    a_rd_answer: assert property (@(posedge s_axi_aclk_in)
        disable iff (!s_axi_aresetn_in) s_axi_arvalid_in && !s_axi_rvalid_out
        && !s_axi_arready_out |=> s_axi_arready_out && s_axi_rvalid_out)
        else $error("Read");
    c_stall: cover property (@(posedge mclk_in)
        pout_tvalid_out && !pout_tready_in);
    c_single: cover property (@(posedge mclk_in)
        hs && pout_tuser_out.sop && pout_tlast_out);
    c_write: cover property (@(posedge s_axi_aclk_in)
        s_axi_bvalid_out && s_axi_bready_in);
endmodule

bind vtx_out_port vtx_out_port_props u_props (.*);

// ==== vtx_pkg.sv ====
// Types shared by the packet output port
package vtx_pkg;
    // Which producer a packet came from
    typedef enum logic [1:0] {
        VTX_SRC_MEDIA,
        VTX_SRC_COL,
        VTX_SRC_ROW
    } vtx_src_t;

    // Packet descriptor that rides with each source word
    typedef struct packed {
        vtx_src_t    src;
        logic [3:0]  media_type;
        logic [11:0] chan;
        logic [10:0] len;
    } vtx_desc_t;

    // Outgoing 32-bit sideband field, bit 31 first
    typedef struct packed {
        logic [3:0]  ptype;
        logic        rsv27;
        logic [10:0] len;
        logic        rsv15;
        logic [11:0] chan;
        logic [1:0]  ver;
        logic        sop;
    } vtx_user_t;
endpackage

// ==== vtx_sink.sv ====
// Downstream packet sink model with a fixed stall pattern
`timescale 1ns/100ps
module vtx_sink (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    // Ready back to the port
    output logic      ready_out
);
    logic [2:0] phase = 3'h0;
    initial ready_out = 1'b0;
    // Lone stall at 2, long stall at 6-7, so both quick and slow takes
    always @(posedge mclk_in) begin
        phase <= sys_rst_in ? 3'h0 : phase + 3'h1;
        ready_out <= !sys_rst_in && phase != 3'h2 && phase[2:1] != 2'h3;
    end
endmodule
